//--- core/plt_lookup.sv
// Piecewise lookup table engine with a classic Wishbone register slave
//
// Contract
// [R1] Eleven breakpoints form at most ten output segments.
// [R2] Axis type 0: the source value is the lookup argument.
// [R3] Axis type 1: the argument is elapsed time in milliseconds.
// [R4] In time mode the source only enables the timer.
// [R5] Each point's shape code: 0 ignore, 1 ramp, 2 step.
// [R6] Ramp segments interpolate linearly between the two points.
// [R7] Step segments output this point's Y for inputs up to its X.
// [R8] Point zero is always a step and cannot be rewritten.
// [R9] An ignored point ends the table there.
// [R10] Input or math sources bound X and rescale X on range change.
// [R11] Other sources bound X to -100000 .. 1000000.
// [R12] X values stay non-decreasing and inside the limits.
// [R13] Software should edit the highest X first, then go downward.
// [R14] Y values are stored with no ordering check.
// [R15] Output min and max are the smallest and largest Y.
// [R16] Ignored points take no part in min and max.
// [R17] Elapsed time holds zero when disabled, else counts milliseconds.
// [R18] Inputs beyond the last point hold that point's Y.
`timescale 1ns/1ps
`include "plt_params.svh"
module plt_lookup #(
    parameter int MS_CYCLES = `PLT_MS_NS / `PLT_CLK_NS,
    parameter int NPTS      = `PLT_NPTS
) (
    // Clock and reset
    input  wire logic               I_MCLK,
    input  wire logic               I_RST,
    // Wishbone slave
    input  wire logic               I_WB_CYC,
    input  wire logic               I_WB_STB,
    input  wire logic               I_WB_WE,
    input  wire logic [7:0]         I_WB_ADR,
    input  wire logic [3:0]         I_WB_SEL,
    input  wire logic [31:0]        I_WB_DAT,
    output logic      [31:0]        O_WB_DAT,
    output logic                    O_WB_ACK,
    // Selected source signal and its range
    input  wire logic signed [31:0] I_SRC_VALUE,
    input  wire logic signed [31:0] I_SRC_MIN,
    input  wire logic signed [31:0] I_SRC_MAX,
    // Table output
    output logic signed [31:0]      O_LUT_OUT,
    output logic signed [31:0]      O_OUT_MIN,
    output logic signed [31:0]      O_OUT_MAX,
    output logic                    O_OUT_VALID
);
    localparam int         MSW  = $clog2(MS_CYCLES + 1);
    localparam logic [3:0] LAST = 4'(NPTS - 1);

    plt_pkg::plt_state_t state_q;
    plt_pkg::plt_src_t   src_q;
    logic [3:0]          idx_q;
    logic                axis_q;
    logic signed [31:0]  rmin_q;
    logic signed [31:0]  rmax_q;
    logic signed [31:0]  omin_q;
    logic signed [31:0]  omax_q;
    logic signed [31:0]  arg_q;
    logic signed [31:0]  prev_x_q;
    logic signed [31:0]  prev_y_q;
    logic signed [31:0]  res_q;
    logic signed [31:0]  min_q;
    logic signed [31:0]  max_q;
    logic                found_q;
    logic signed [31:0]  out_q;
    logic signed [31:0]  omn_q;
    logic signed [31:0]  omx_q;
    logic                valid_q;
    logic [3:0]          act_q;
    logic signed [31:0]  wr_val_q;
    logic signed [31:0]  lo_q;
    logic                ack_q;
    logic [31:0]         dat_q;
    logic [MSW-1:0]      ms_cnt_q;
    logic [31:0]         elapsed_q;

    logic                req;
    logic [1:0]          region;
    logic [3:0]          pidx;
    logic                pt_ok;
    logic                src_ranged;
    logic                rng_chg;
    logic                scan_go;
    logic                src_en;
    logic signed [31:0]  xlo_lim;
    logic signed [31:0]  xhi_lim;
    logic signed [31:0]  x_hi_nb;
    logic [31:0]         reg_rd;
    plt_pkg::plt_shape_t e_shape;
    logic                e_active;
    logic                e_hit;
    logic                e_last;
    logic signed [31:0]  e_res;
    logic signed [31:0]  e_min;
    logic signed [31:0]  e_max;

    plt_mem_if mem ();

    plt_point_mem #(
        .DEPTH (NPTS)
    ) u_mem (
        .i_clk (I_MCLK),
        .i_rst (I_RST),
        .bus   (mem.mem)
    );

    // Returns b + (v - v0) * (n1 - n0) / (d1 - d0); a zero span yields b
    function automatic logic signed [31:0] plt_scale(
        input logic signed [31:0] b, input logic signed [31:0] v, input logic signed [31:0] v0,
        input logic signed [31:0] n1, input logic signed [31:0] n0,
        input logic signed [31:0] d1, input logic signed [31:0] d0);
        logic signed [63:0] num;
        logic signed [63:0] den;
        num = (64'(v) - 64'(v0)) * (64'(n1) - 64'(n0));
        den = 64'(d1) - 64'(d0);
        if (den == 64'sh0) begin
            return b;
        end
        return 32'(64'(b) + num / den);
    endfunction

    // Holds v inside lo .. hi
    function automatic logic signed [31:0] plt_clamp(
        input logic signed [31:0] v, input logic signed [31:0] lo, input logic signed [31:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    // Bus decode; point words need all four byte lanes
    assign req     = I_WB_CYC && I_WB_STB && !ack_q && (state_q == plt_pkg::ST_IDLE);
    assign region  = I_WB_ADR[7:6];
    assign pidx    = I_WB_ADR[5:2];
    assign pt_ok   = (region != 2'h0) && (pidx <= LAST) && (I_WB_SEL == 4'hF);
    assign scan_go = (state_q == plt_pkg::ST_IDLE) && !req && !rng_chg;

    // X limits follow the source kind
    assign src_ranged = (src_q == plt_pkg::PLT_SRC_INPUT) || (src_q == plt_pkg::PLT_SRC_MATH);
    assign xlo_lim    = src_ranged ? rmin_q : `PLT_XMIN_OTHER; // [R10] [R11]
    assign xhi_lim    = src_ranged ? rmax_q : `PLT_XMAX_OTHER; // [R10] [R11]
    assign rng_chg    = src_ranged && ((I_SRC_MIN != rmin_q) || (I_SRC_MAX != rmax_q)); // [R10]
    assign x_hi_nb    = (idx_q == LAST) ? xhi_lim : mem.rx;

    // Register read mux
    always_comb begin
        if (I_WB_ADR == `PLT_OFF_CTRL) begin
            reg_rd = {29'h0, src_q, axis_q};
        end else if (I_WB_ADR == `PLT_OFF_OUT) begin
            reg_rd = out_q;
        end else if (I_WB_ADR == `PLT_OFF_MIN) begin
            reg_rd = omn_q;
        end else if (I_WB_ADR == `PLT_OFF_MAX) begin
            reg_rd = omx_q;
        end else if (I_WB_ADR == `PLT_OFF_STAT) begin
            reg_rd = {27'h0, valid_q, act_q};
        end else if (I_WB_ADR == `PLT_OFF_TIME) begin
            reg_rd = elapsed_q;
        end else begin
            reg_rd = 32'h0;
        end
    end

    // Memory port steering: Y and shape bus writes in idle, neighbour reads for X writes
    always_comb begin
        mem.addr = idx_q;
        mem.we_x = 1'b0;
        mem.we_y = 1'b0;
        mem.we_s = 1'b0;
        mem.wx   = wr_val_q;
        mem.wy   = I_WB_DAT;
        mem.ws   = plt_pkg::plt_shape_t'(I_WB_DAT[1:0]);
        case (state_q)
            plt_pkg::ST_IDLE: begin
                mem.addr = pidx;
                mem.we_y = req && pt_ok && I_WB_WE && (region == `PLT_RGN_Y); // [R14]
                // Point zero keeps its step shape; code 3 has no meaning
                mem.we_s = req && pt_ok && I_WB_WE && (region == `PLT_RGN_S)
                           && (pidx != 4'h0) && (I_WB_DAT[1:0] != 2'h3); // [R5] [R8]
            end
            plt_pkg::ST_XLO: mem.addr = idx_q - 4'h1;
            plt_pkg::ST_XHI: mem.addr = idx_q + 4'h1;
            plt_pkg::ST_XPUT: begin
                mem.we_x = 1'b1;
                mem.wx   = plt_clamp(wr_val_q, lo_q, x_hi_nb); // [R12] [R13]
            end
            plt_pkg::ST_RESC_WR: begin
                mem.we_x = 1'b1;
                mem.wx   = plt_scale(rmin_q, mem.rx, omin_q, rmax_q, rmin_q, omax_q, omin_q); // [R10]
            end
            default: mem.addr = idx_q;
        endcase
    end

    // Main sequencer: bus service, X edits, rescale, table scan
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            state_q  <= plt_pkg::ST_IDLE;
            idx_q    <= 4'h0;
            ack_q    <= 1'b0;
            dat_q    <= 32'h0;
            wr_val_q <= 32'h0;
            lo_q     <= 32'h0;
            rmin_q   <= 32'h0;
            rmax_q   <= 32'h0;
            omin_q   <= 32'h0;
            omax_q   <= 32'h0;
        end else begin
            ack_q <= 1'b0;
            case (state_q)
                plt_pkg::ST_IDLE: begin
                    idx_q <= 4'h0;
                    if (req) begin
                        idx_q <= pidx;
                        if (pt_ok && !I_WB_WE) begin
                            state_q <= plt_pkg::ST_PRD;
                        end else if (pt_ok && region == `PLT_RGN_X) begin
                            wr_val_q <= plt_clamp(I_WB_DAT, xlo_lim, xhi_lim); // [R12]
                            state_q  <= plt_pkg::ST_XLO;
                        end else begin
                            ack_q <= 1'b1;
                            dat_q <= reg_rd;
                        end
                    end else if (rng_chg) begin
                        // Old range kept so every X maps proportionally
                        omin_q  <= rmin_q;
                        omax_q  <= rmax_q;
                        rmin_q  <= I_SRC_MIN;
                        rmax_q  <= I_SRC_MAX;
                        state_q <= plt_pkg::ST_RESC_RD;
                    end else begin
                        state_q <= plt_pkg::ST_SCAN;
                    end
                end
                plt_pkg::ST_PRD: state_q <= plt_pkg::ST_PRD2;
                plt_pkg::ST_PRD2: begin
                    ack_q   <= 1'b1;
                    state_q <= plt_pkg::ST_IDLE;
                    if (region == `PLT_RGN_X) begin
                        dat_q <= mem.rx;
                    end else if (region == `PLT_RGN_Y) begin
                        dat_q <= mem.ry;
                    end else begin
                        dat_q <= {30'h0, mem.rs};
                    end
                end
                plt_pkg::ST_XLO: state_q <= plt_pkg::ST_XHI;
                plt_pkg::ST_XHI: begin
                    lo_q    <= (idx_q == 4'h0) ? xlo_lim : mem.rx; // [R12]
                    state_q <= plt_pkg::ST_XPUT;
                end
                plt_pkg::ST_XPUT: begin
                    ack_q   <= 1'b1;
                    state_q <= plt_pkg::ST_IDLE;
                end
                plt_pkg::ST_RESC_RD: state_q <= plt_pkg::ST_RESC_WR;
                plt_pkg::ST_RESC_WR: begin
                    idx_q   <= idx_q + 4'h1;
                    state_q <= (idx_q == LAST) ? plt_pkg::ST_IDLE : plt_pkg::ST_RESC_RD;
                end
                plt_pkg::ST_SCAN: state_q <= plt_pkg::ST_SEV;
                plt_pkg::ST_SEV: begin
                    idx_q   <= idx_q + 4'h1;
                    state_q <= e_last ? plt_pkg::ST_IDLE : plt_pkg::ST_SCAN; // [R1] [R9]
                end
                default: state_q <= plt_pkg::ST_IDLE;
            endcase
        end
    end

    // Evaluation of one breakpoint during the scan
    always_comb begin
        e_shape  = (idx_q == 4'h0) ? plt_pkg::PLT_SHAPE_STEP : mem.rs; // [R8]
        e_active = (idx_q == 4'h0) || (e_shape != plt_pkg::PLT_SHAPE_IGNORE); // [R9]
        e_hit    = e_active && !found_q && (arg_q <= mem.rx);
        e_last   = !e_active || (idx_q == LAST); // [R1] [R9]
        if (e_hit && e_shape == plt_pkg::PLT_SHAPE_RAMP) begin
            e_res = plt_scale(prev_y_q, arg_q, prev_x_q, mem.ry, prev_y_q, mem.rx, prev_x_q); // [R6]
        end else if (e_hit || (!found_q && e_active)) begin
            e_res = mem.ry; // [R7] [R18]
        end else begin
            e_res = res_q;
        end
        // Ignored points leave the extremes alone
        e_min = min_q;
        e_max = max_q;
        if (idx_q == 4'h0 || (e_active && mem.ry < min_q)) begin
            e_min = mem.ry; // [R15] [R16]
        end
        if (idx_q == 4'h0 || (e_active && mem.ry > max_q)) begin
            e_max = mem.ry; // [R15] [R16]
        end
    end

    // Scan accumulators and published results
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            arg_q    <= 32'h0;
            found_q  <= 1'b0;
            res_q    <= 32'h0;
            prev_x_q <= 32'h0;
            prev_y_q <= 32'h0;
            min_q    <= 32'h0;
            max_q    <= 32'h0;
            out_q    <= 32'h0;
            omn_q    <= 32'h0;
            omx_q    <= 32'h0;
            valid_q  <= 1'b0;
            act_q    <= 4'h0;
        end else if (scan_go) begin
            // Argument frozen for a whole pass
            arg_q   <= axis_q ? elapsed_q : I_SRC_VALUE; // [R2] [R3]
            found_q <= 1'b0;
        end else if (state_q == plt_pkg::ST_SEV) begin
            found_q  <= found_q || e_hit;
            res_q    <= e_res;
            prev_x_q <= mem.rx;
            prev_y_q <= mem.ry;
            min_q    <= e_min;
            max_q    <= e_max;
            if (e_last) begin
                out_q   <= e_res;
                omn_q   <= e_min;
                omx_q   <= e_max;
                valid_q <= 1'b1;
                act_q   <= e_active ? idx_q + 4'h1 : idx_q;
            end
        end
    end

    // Control register; only byte lane 0 carries fields
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            axis_q <= 1'(`PLT_CTRL_RST >> `PLT_CTRL_AXIS);
            src_q  <= plt_pkg::plt_src_t'(2'(`PLT_CTRL_RST >> `PLT_CTRL_SRC));
        end else if (req && I_WB_WE && I_WB_ADR == `PLT_OFF_CTRL && I_WB_SEL[0]) begin
            axis_q <= I_WB_DAT[`PLT_CTRL_AXIS];
            src_q  <= plt_pkg::plt_src_t'(I_WB_DAT[`PLT_CTRL_SRC+1:`PLT_CTRL_SRC]);
        end
    end

    // Millisecond timer; saturates instead of wrapping negative
    assign src_en = (I_SRC_VALUE != 32'h0); // [R4]
    always_ff @(posedge I_MCLK) begin
        if (I_RST || !axis_q || !src_en) begin
            ms_cnt_q  <= '0; // [R17]
            elapsed_q <= 32'h0;
        end else if (ms_cnt_q == MSW'(MS_CYCLES - 1)) begin
            ms_cnt_q <= '0;
            if (elapsed_q != 32'h7FFF_FFFF) begin
                elapsed_q <= elapsed_q + 32'h1; // [R17]
            end
        end else begin
            ms_cnt_q <= ms_cnt_q + MSW'(1);
        end
    end

    assign O_WB_ACK    = ack_q;
    assign O_WB_DAT    = dat_q;
    assign O_LUT_OUT   = out_q;
    assign O_OUT_MIN   = omn_q;
    assign O_OUT_MAX   = omx_q;
    assign O_OUT_VALID = valid_q;

    // Checks
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RST);

    property p_ack_pulse;
        O_WB_ACK |=> !O_WB_ACK;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");

    property p_pt0_step;
        (state_q == plt_pkg::ST_PRD2 && idx_q == 4'h0 && region == `PLT_RGN_S) |=> O_WB_DAT == 32'h0000_0002;
    endproperty
    a_pt0_step: assert property (p_pt0_step) else $error("point zero shape not step"); // [R8]

    property p_x_order;
        (state_q == plt_pkg::ST_XPUT && lo_q <= x_hi_nb) |-> mem.wx >= lo_q && mem.wx <= x_hi_nb;
    endproperty
    a_x_order: assert property (p_x_order) else $error("X write breaks ordering"); // [R12]

    property p_min_max;
        O_OUT_VALID |-> O_OUT_MIN <= O_OUT_MAX;
    endproperty
    a_min_max: assert property (p_min_max) else $error("output min above max"); // [R15]

    property p_out_range;
        O_OUT_VALID |-> O_LUT_OUT >= O_OUT_MIN && O_LUT_OUT <= O_OUT_MAX;
    endproperty
    a_out_range: assert property (p_out_range) else $error("output outside Y range"); // [R6]

    property p_time_idle;
        (!axis_q || !src_en) |=> elapsed_q == 32'h0;
    endproperty
    a_time_idle: assert property (p_time_idle) else $error("elapsed time not cleared"); // [R17]

    property p_time_step;
        ($past(axis_q) && $past(src_en) && $changed(elapsed_q)) |-> elapsed_q == $past(elapsed_q) + 32'h1;
    endproperty
    a_time_step: assert property (p_time_step) else $error("elapsed time jumped"); // [R17]

    property p_ms_gap;
        ($changed(elapsed_q) && elapsed_q != 32'h0) |-> $past(ms_cnt_q) == MSW'(MS_CYCLES - 1);
    endproperty
    a_ms_gap: assert property (p_ms_gap) else $error("elapsed time early"); // [R17]

    property p_arg_sel;
        scan_go |=> arg_q == ($past(axis_q) ? $past(elapsed_q) : $past(I_SRC_VALUE));
    endproperty
    a_arg_sel: assert property (p_arg_sel) else $error("wrong lookup argument"); // [R2] [R3]

    property p_ignore_stop;
        (state_q == plt_pkg::ST_SEV && idx_q != 4'h0 && mem.rs == plt_pkg::PLT_SHAPE_IGNORE)
            |=> state_q == plt_pkg::ST_IDLE ##1 state_q != plt_pkg::ST_SEV;
    endproperty
    a_ignore_stop: assert property (p_ignore_stop) else $error("scan ran past ignored point"); // [R9]

    property p_step_val;
        (state_q == plt_pkg::ST_SEV && e_hit && mem.rs == plt_pkg::PLT_SHAPE_STEP) |=> res_q == $past(mem.ry);
    endproperty
    a_step_val: assert property (p_step_val) else $error("step did not give point Y"); // [R7]

    c_time_mode: cover property (axis_q && src_en && O_OUT_VALID && elapsed_q != 32'h0);
    c_ramp_hit:  cover property (state_q == plt_pkg::ST_SEV && e_hit && e_shape == plt_pkg::PLT_SHAPE_RAMP);
    c_rescale:   cover property (state_q == plt_pkg::ST_RESC_WR && idx_q == LAST);
    c_x_write:   cover property (state_q == plt_pkg::ST_XPUT);
endmodule

//--- core/plt_params.svh
// Register offsets, field positions, reset values and timing for the lookup table
`ifndef PLT_PARAMS_SVH
`define PLT_PARAMS_SVH
// Plain register offsets
`define PLT_OFF_CTRL   8'h00
`define PLT_OFF_OUT    8'h04
`define PLT_OFF_MIN    8'h08
`define PLT_OFF_MAX    8'h0C
`define PLT_OFF_STAT   8'h10
`define PLT_OFF_TIME   8'h14
// Point regions: X at 8'h40, Y at 8'h80, shape at 8'hC0, one word per point
`define PLT_RGN_X      2'h1
`define PLT_RGN_Y      2'h2
`define PLT_RGN_S      2'h3
// Control fields
`define PLT_CTRL_AXIS  0
`define PLT_CTRL_SRC   1
// Reset values and point count
`define PLT_CTRL_RST   3'h0
`define PLT_NPTS       11
// X limits when the source has no range of its own: -100000 and 1000000
`define PLT_XMIN_OTHER (-32'sh0001_86A0)
`define PLT_XMAX_OTHER (32'sh000F_4240)
// Time base: one millisecond in ns, clock period in ns
`define PLT_MS_NS      1000000
`define PLT_CLK_NS     5
`endif

//--- core/plt_pkg.sv
// Types shared by the lookup table modules
package plt_pkg;
    typedef enum logic [1:0] {
        PLT_SHAPE_IGNORE = 2'h0,
        PLT_SHAPE_RAMP   = 2'h1,
        PLT_SHAPE_STEP   = 2'h2
    } plt_shape_t;
    typedef enum logic [1:0] {
        PLT_SRC_OTHER = 2'h0,
        PLT_SRC_INPUT = 2'h1,
        PLT_SRC_MATH  = 2'h2
    } plt_src_t;
    typedef enum logic [3:0] {
        ST_IDLE, ST_PRD, ST_PRD2, ST_XLO, ST_XHI, ST_XPUT, ST_RESC_RD, ST_RESC_WR, ST_SCAN, ST_SEV
    } plt_state_t;
endpackage

//--- core/plt_mem_if.sv
// Port between the lookup engine and its breakpoint storage
`timescale 1ns/1ps
interface plt_mem_if;
    logic [3:0]          addr;
    logic                we_x;
    logic                we_y;
    logic                we_s;
    logic signed [31:0]  wx;
    logic signed [31:0]  wy;
    plt_pkg::plt_shape_t ws;
    logic signed [31:0]  rx;
    logic signed [31:0]  ry;
    plt_pkg::plt_shape_t rs;
    modport ctl (output addr, we_x, we_y, we_s, wx, wy, ws, input rx, ry, rs);
    modport mem (input addr, we_x, we_y, we_s, wx, wy, ws, output rx, ry, rs);
endinterface

//--- core/plt_point_mem.sv
// Breakpoint storage with a registered read port
`timescale 1ns/1ps
`include "plt_params.svh"
module plt_point_mem #(
    parameter int DEPTH = `PLT_NPTS
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Access port
    plt_mem_if.mem    bus
);
    logic signed [31:0]  x_mem [DEPTH];
    logic signed [31:0]  y_mem [DEPTH];
    plt_pkg::plt_shape_t s_mem [DEPTH];
    logic                hit;

    assign hit = (int'(bus.addr) < DEPTH);

    // Writes; reset leaves only the first point active
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                x_mem[i] <= 32'h0;
                y_mem[i] <= 32'h0;
                s_mem[i] <= (i == 0) ? plt_pkg::PLT_SHAPE_STEP : plt_pkg::PLT_SHAPE_IGNORE;
            end
        end else if (hit) begin
            if (bus.we_x) begin
                x_mem[bus.addr] <= bus.wx;
            end
            if (bus.we_y) begin
                y_mem[bus.addr] <= bus.wy;
            end
            if (bus.we_s) begin
                s_mem[bus.addr] <= bus.ws;
            end
        end
    end

    // Registered read; addresses past the table read as zero
    always_ff @(posedge i_clk) begin
        if (i_rst || !hit) begin
            bus.rx <= 32'h0;
            bus.ry <= 32'h0;
            bus.rs <= plt_pkg::PLT_SHAPE_IGNORE;
        end else begin
            bus.rx <= x_mem[bus.addr];
            bus.ry <= y_mem[bus.addr];
            bus.rs <= s_mem[bus.addr];
        end
    end
endmodule

//--- testbench/plt_lookup_tb.sv
// Self-checking bench for the lookup table block
`timescale 1ns/1ps
module plt_lookup_tb;
    logic               I_MCLK, I_RST, cyc, stb, we, ack;
    logic        [3:0]  sel, bsel;
    logic        [7:0]  adr;
    logic        [31:0] wdat, rdat, q;
    logic signed [31:0] src_v, src_lo, src_hi, lut_out, out_min, out_max;
    logic               out_valid;
    logic signed [31:0] ys[4];
    logic signed [31:0] v, mn, mx;
    int                 failures, checks;
    // Short millisecond so the time base is reachable
    plt_lookup #(.MS_CYCLES(10)) DUT (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_WB_CYC(cyc), .I_WB_STB(stb),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .I_SRC_VALUE(src_v), .I_SRC_MIN(src_lo), .I_SRC_MAX(src_hi), .O_LUT_OUT(lut_out),
        .O_OUT_MIN(out_min), .O_OUT_MAX(out_max), .O_OUT_VALID(out_valid));
    // Clock at 200 MHz
    initial begin
        I_MCLK = 1'b0;
        forever #2.5 I_MCLK = ~I_MCLK;
    end
    // Verdict, printed once
    task automatic final_report();
        if (failures == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Classic single cycle; the slave may stall while a scan runs, so wait on ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge I_MCLK);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= bsel;
        n = 0;
        do begin
            @(posedge I_MCLK);
            n++;
        end while (ack !== 1'b1 && n < 200);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        if (ack !== 1'b1) begin
            failures++;
            final_report();
        end
    endtask
    // Expected output: points 0..3 at X=0,100,200,300; 1 ramp, 2 step, 3 ramp
    function automatic logic signed [31:0] f_eval(input logic signed [31:0] x);
        if (x <= 0) return ys[0];
        for (int n = 1; n < 4; n++)
            if (x <= n * 100)
                return (n == 2) ? ys[2] : ys[n-1] + (ys[n] - ys[n-1]) * (x - (n - 1) * 100) / 100;
        return ys[3];
    endfunction
    initial begin
        {cyc, stb, we, sel, adr, wdat, src_v, src_lo, src_hi, failures, checks} = '0;
        bsel = 4'hF;
        I_RST = 1'b1;
        void'($urandom(90));
        repeat (12) @(posedge I_MCLK);
        I_RST <= 1'b0;
        wb(0, 8'h00, 0); chk("ctrl_reset", q, 32'h0);
        wb(0, 8'hC0, 0); chk("shape0_reset", q, 32'h2);
        wb(0, 8'hC4, 0); chk("shape1_reset", q, 32'h0);
        wb(1, 8'hC0, 32'h1); wb(0, 8'hC0, 0); chk("shape0_locked", q, 32'h2);
        wb(0, 8'h20, 0); chk("unmapped", q, 32'h0);
        wb(0, 8'h6C, 0); chk("x11_absent", q, 32'h0);
        // Build the table highest X first, as software should
        for (int n = 10; n >= 0; n--) wb(1, 8'h40 + 8'(4 * n), (n >= 3) ? 32'(300) : 32'(n * 100));
        for (int n = 0; n < 4; n++) begin
            ys[n] = 32'($urandom_range(1000)) + 100;
            wb(1, 8'h80 + 8'(4 * n), ys[n]);
        end
        wb(1, 8'h94, 32'h0000_2710); // Ignored point must not reach max
        wb(1, 8'hC4, 32'h1); wb(1, 8'hC8, 32'h2); wb(1, 8'hCC, 32'h1);
        wb(1, 8'hC4, 32'h3); wb(0, 8'hC4, 0); chk("shape_bad_code", q, 32'h1);
        // Partial byte lanes on a point word are refused
        bsel = 4'h3;
        wb(1, 8'h84, 32'h0000_5555);
        bsel = 4'hF;
        wb(0, 8'h84, 0); chk("y1_sel_refused", q, ys[1]);
        mn = ys[0]; mx = ys[0];
        for (int n = 1; n < 4; n++) begin
            if (ys[n] < mn) mn = ys[n];
            if (ys[n] > mx) mx = ys[n];
        end
        // Corner inputs then random ones, including beyond the last point
        for (int k = 0; k < 24; k++) begin
            v = (k < 8) ? 32'(k * 60 - 50) : 32'($urandom_range(500)) - 100;
            src_v <= v;
            repeat (60) @(posedge I_MCLK);
            chk("lut_out", lut_out, f_eval(v));
        end
        chk("out_min", out_min, mn);
        chk("out_max", out_max, mx);
        chk("out_valid", out_valid, 1'b1);
        wb(0, 8'h10, 0); chk("stat", q, 32'h14);
        // Limits for a source with no range of its own
        wb(1, 8'h68, 32'd2000000); wb(0, 8'h68, 0); chk("x10_clamp", q, 32'd1000000);
        wb(1, 8'h40, -32'sd200000); wb(0, 8'h40, 0); chk("x0_clamp", q, -32'sd100000);
        wb(1, 8'h48, 32'd50); wb(0, 8'h48, 0); chk("x2_order", q, 32'd100);
        // Time axis: source is only an enable
        src_v <= 0;
        wb(1, 8'h00, 32'h1);
        repeat (30) @(posedge I_MCLK);
        wb(0, 8'h14, 0); chk("time_idle", q, 32'h0);
        src_v <= 32'sd7;
        repeat (55) @(posedge I_MCLK);
        wb(0, 8'h14, 0); chk("time_run", (q >= 4 && q <= 9), 1'b1);
        src_v <= 0;
        repeat (3) @(posedge I_MCLK);
        wb(0, 8'h14, 0); chk("time_clear", q, 32'h0);
        // Ranged source: X follows the source range
        wb(1, 8'h00, 32'h2);
        src_lo <= 32'sd50; src_hi <= 32'sd500;
        repeat (80) @(posedge I_MCLK);
        wb(0, 8'h4C, 0); chk("x3_rescale", q, 32'd50);
        src_lo <= 32'sd100; src_hi <= 32'sd1000;
        repeat (80) @(posedge I_MCLK);
        wb(0, 8'h5C, 0); chk("x7_rescale", q, 32'd100);
        wb(1, 8'h40, 32'd10); wb(0, 8'h40, 0); chk("x0_src_clamp", q, 32'd100);
        // Math source, then the results as seen through the registers
        wb(1, 8'h00, 32'h4);
        src_lo <= 32'sd0; src_hi <= 32'sd900;
        repeat (80) @(posedge I_MCLK);
        wb(0, 8'h68, 0); chk("x10_math_rescale", q, 32'h0);
        wb(0, 8'h04, 0); chk("out_reg", q, ys[0]);
        wb(0, 8'h08, 0); chk("min_reg", q, mn);
        wb(0, 8'h0C, 0); chk("max_reg", q, mx);
        final_report();
    end
endmodule
